//--- amc_pkg.sv
// constants and types shared by the amplifier mode and clock-role logic
// assumes a 25 MHz pclk and an APB master with 8-bit byte addresses
package amc_pkg;

   // clock and timing
   localparam int unsigned CLK_KHZ      = 25000;
   localparam int unsigned OSC_KHZ      = 320;
   localparam int unsigned LINK_DIV     = 4;
   localparam int unsigned SHCLK_HALF   = CLK_KHZ / (2 * OSC_KHZ * LINK_DIV);
   localparam int unsigned CHARGE_US    = 100;
   localparam int unsigned CHARGE_CYC   = (CHARGE_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned RAMP_STEP_US = 4;
   localparam int unsigned RAMP_CYC     = (RAMP_STEP_US * CLK_KHZ + 999) / 1000;

   // counter, gain and address widths
   localparam int unsigned CHG_W   = 12;
   localparam int unsigned RAMP_W  = 7;
   localparam int unsigned SHC_W   = 4;
   localparam int unsigned GAIN_W  = 8;
   localparam int unsigned PHASE_W = 2;
   localparam int unsigned ADDR_W  = 8;

   localparam logic [GAIN_W-1:0] GAIN_MAX = 8'hFF;
   localparam logic [GAIN_W-1:0] GAIN_MIN = 8'h00;

   // register map
   localparam logic [ADDR_W-1:0] ADDR_CMD    = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

   // field positions
   localparam int unsigned CB1_LSB    = 0;
   localparam int unsigned CB2_LSB    = 8;
   localparam int unsigned IB_W       = 8;
   localparam int unsigned CMD_D0     = 0;
   localparam int unsigned ST_STATE   = 0;
   localparam int unsigned ST_BUS     = 4;
   localparam int unsigned ST_MASTER  = 5;
   localparam int unsigned ST_GAIN    = 6;
   localparam int unsigned ST_CHARGED = 14;

   typedef enum logic [3:0] {
      AMC_OFF     = 4'h1,
      AMC_STANDBY = 4'h2,
      AMC_MUTE    = 4'h4,
      AMC_OPER    = 4'h8
   } amc_state_t;

endpackage

//--- amc_link_div.sv
// link-side divider clocked by the shared clock pin in slave role
// assumes presetn is asynchronous; the link clock may stop between uses
`timescale 1ns/100ps
module amc_link_div
(
   input  wire logic link_clk,
   input  wire logic presetn,
   output logic      phase_msb
);

   typedef struct packed {
      logic [amc_pkg::PHASE_W-1:0] phase;
   } amc_link_st_t;

   amc_link_st_t st_reg;
   amc_link_st_t st_next;

   // divide before crossing so the msb changes slower than pclk samples
   always_comb
   begin
      st_next       = st_reg;
      st_next.phase = st_reg.phase + 2'h1;
   end

   always_ff @(posedge link_clk or negedge presetn)
   begin
      if (!presetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign phase_msb = st_reg.phase[amc_pkg::PHASE_W-1];

endmodule

//--- amc_mode_clock.sv
// amplifier mode selection and clock-role logic with an APB register file
// assumes pins and straps are asynchronous; shared clock input is a clock
//
// What this block does
// - power-on low forces fully off state
// - bus commands ignored while off
// - power-on high enables the device
// - open address strap selects bus control
// - bus mode enables into standby, awaits commands
// - grounded strap selects pin-only, default mute
// - mute keeps bridges switching, audio suppressed
// - pin mode operates after release and charge
// - gain ramps smoothly on mute and unmute
// - instruction bits D0 choose operate, mute, standby
// - bridges switch at the oscillator frequency
// - timing resistor present makes clock master
// - shorted timing pin makes clock slave
`timescale 1ns/100ps
module amc_mode_clock
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        power_on_pin,
   input  wire logic        quiet_release_pin,
   input  wire logic        bus_address_strap,
   input  wire logic        timing_resistor_pin,
   input  wire logic        shared_clock_pin_i,
   output logic             shared_clock_pin_o,
   output logic             shared_clock_pin_oe_n,
   output logic             bridge_switch,
   output logic             bridge_active,
   output logic [7:0]       audio_gain,
   output logic [3:0]       amp_state
);

   typedef struct packed {
      logic                          pon_s1;
      logic                          pon_s2;
      logic                          qr_s1;
      logic                          qr_s2;
      logic                          bas_s1;
      logic                          bas_s2;
      logic                          tmr_s1;
      logic                          tmr_s2;
      logic                          lnk_s1;
      logic                          lnk_s2;
      amc_pkg::amc_state_t           state;
      logic                          bus_mode;
      logic                          master;
      logic [amc_pkg::IB_W-1:0]      cb1;
      logic [amc_pkg::IB_W-1:0]      cb2;
      logic [amc_pkg::CHG_W-1:0]     chg_cnt;
      logic                          charged;
      logic [amc_pkg::RAMP_W-1:0]    ramp_cnt;
      logic [amc_pkg::GAIN_W-1:0]    gain;
      logic [amc_pkg::SHC_W-1:0]     shc_cnt;
      logic                          shclk;
      logic [amc_pkg::PHASE_W-1:0]   phase;
      logic                          brg;
      logic                          active;
      logic [31:0]                   rdata;
      logic                          err;
   } amc_st_t;

   amc_st_t st_reg;
   amc_st_t st_next;
   logic    link_msb;

   amc_link_div u_link_div
   (
      .link_clk  (shared_clock_pin_i),
      .presetn   (presetn),
      .phase_msb (link_msb)
   );

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == amc_pkg::ADDR_CMD) || (a == amc_pkg::ADDR_STATUS);
   endfunction

   function automatic amc_pkg::amc_state_t bus_decode(input logic b1, input logic b2);
      if (!b1)
         bus_decode = amc_pkg::AMC_STANDBY;
      else if (b2)
         bus_decode = amc_pkg::AMC_MUTE;
      else
         bus_decode = amc_pkg::AMC_OPER;
   endfunction

   logic setup_ph;
   logic wr_acc;
   logic pin_op;
   logic shc_wrap;
   logic carrier_src;

   always_comb
   begin
      st_next     = st_reg;
      setup_ph    = psel && !penable;
      wr_acc      = psel && penable && pwrite;
      pin_op      = 1'b0;
      shc_wrap    = 1'b0;
      carrier_src = 1'b0;

      // two-flop synchronisers on every outside level
      st_next.pon_s1 = power_on_pin;
      st_next.pon_s2 = st_reg.pon_s1;
      st_next.qr_s1  = quiet_release_pin;
      st_next.qr_s2  = st_reg.qr_s1;
      st_next.bas_s1 = bus_address_strap;
      st_next.bas_s2 = st_reg.bas_s1;
      st_next.tmr_s1 = timing_resistor_pin;
      st_next.tmr_s2 = st_reg.tmr_s1;
      st_next.lnk_s1 = link_msb;
      st_next.lnk_s2 = st_reg.lnk_s1;

      // quiet pin capacitor charge emulation, restarts on every hold
      if (st_reg.qr_s2 && st_reg.state != amc_pkg::AMC_OFF)
      begin
         if (st_reg.chg_cnt == amc_pkg::CHG_W'(amc_pkg::CHARGE_CYC - 1))
            st_next.charged = 1'b1;
         else
            st_next.chg_cnt = st_reg.chg_cnt + 12'h001;
      end
      else
      begin
         st_next.chg_cnt = '0;
         st_next.charged = 1'b0;
      end
      pin_op = st_reg.charged && st_reg.qr_s2;

      // mode state machine
      case (st_reg.state)
         amc_pkg::AMC_OFF:
         begin
            st_next.cb1 = '0;
            st_next.cb2 = '0;
            if (st_reg.pon_s2)
            begin
               // straps latched here so later pin noise cannot flip roles
               st_next.bus_mode = st_reg.bas_s2;
               st_next.master   = st_reg.tmr_s2;
               if (st_reg.bas_s2)
                  st_next.state = amc_pkg::AMC_STANDBY;
               else
                  st_next.state = amc_pkg::AMC_MUTE;
            end
         end
         amc_pkg::AMC_STANDBY,
         amc_pkg::AMC_MUTE,
         amc_pkg::AMC_OPER:
         begin
            if (!st_reg.pon_s2)
               st_next.state = amc_pkg::AMC_OFF;
            else if (st_reg.bus_mode)
               st_next.state = bus_decode(st_reg.cb1[amc_pkg::CMD_D0],
                                          st_reg.cb2[amc_pkg::CMD_D0]);
            else if (pin_op)
               st_next.state = amc_pkg::AMC_OPER;
            else
               st_next.state = amc_pkg::AMC_MUTE;
         end
         default:
         begin
            st_next.state = amc_pkg::AMC_OFF;
         end
      endcase

      // gain ramp: one step per interval, so fades only jump when off forces GAIN_MIN
      if (st_reg.ramp_cnt == amc_pkg::RAMP_W'(amc_pkg::RAMP_CYC - 1))
      begin
         st_next.ramp_cnt = '0;
         if (st_reg.state == amc_pkg::AMC_OPER)
         begin
            if (st_reg.gain != amc_pkg::GAIN_MAX)
               st_next.gain = st_reg.gain + 8'h01;
         end
         else if (st_reg.gain != amc_pkg::GAIN_MIN)
            st_next.gain = st_reg.gain - 8'h01;
      end
      else
         st_next.ramp_cnt = st_reg.ramp_cnt + 7'h01;
      if (st_next.state == amc_pkg::AMC_OFF)
         st_next.gain = amc_pkg::GAIN_MIN;

      // master shared clock divider from pclk
      if (st_reg.state != amc_pkg::AMC_OFF && st_reg.master)
      begin
         shc_wrap = st_reg.shc_cnt == amc_pkg::SHC_W'(amc_pkg::SHCLK_HALF - 1);
         if (shc_wrap)
         begin
            st_next.shc_cnt = '0;
            st_next.shclk   = !st_reg.shclk;
            if (!st_reg.shclk)
               st_next.phase = st_reg.phase + 2'h1;
         end
         else
            st_next.shc_cnt = st_reg.shc_cnt + 4'h1;
      end
      else
      begin
         st_next.shc_cnt = '0;
         st_next.shclk   = 1'b0;
         st_next.phase   = '0;
      end

      // carrier: same division of the shared clock in either role
      if (st_reg.master)
         carrier_src = st_reg.phase[amc_pkg::PHASE_W-1];
      else
         carrier_src = st_reg.lnk_s2;

      // bridges idle at half duty in mute, silent in standby and off
      // from the next state, so bridges stop in the cycle that off starts
      st_next.active = (st_next.state == amc_pkg::AMC_MUTE) ||
                       (st_next.state == amc_pkg::AMC_OPER);
      st_next.brg    = st_next.active && carrier_src;

      // apb write: dropped while off, so commands have no lasting effect
      if (wr_acc && paddr == amc_pkg::ADDR_CMD &&
          st_reg.state != amc_pkg::AMC_OFF && st_reg.pon_s2)
      begin
         st_next.cb1 = pwdata[amc_pkg::CB1_LSB +: amc_pkg::IB_W];
         st_next.cb2 = pwdata[amc_pkg::CB2_LSB +: amc_pkg::IB_W];
      end

      // read data and error prepared in setup, presented in access
      if (setup_ph)
      begin
         st_next.rdata = '0;
         st_next.err   = !addr_mapped(paddr);
         if (!pwrite && paddr == amc_pkg::ADDR_CMD)
         begin
            st_next.rdata[amc_pkg::CB1_LSB +: amc_pkg::IB_W] = st_reg.cb1;
            st_next.rdata[amc_pkg::CB2_LSB +: amc_pkg::IB_W] = st_reg.cb2;
         end
         else if (!pwrite && paddr == amc_pkg::ADDR_STATUS)
         begin
            st_next.rdata[amc_pkg::ST_STATE +: 4]       = st_reg.state;
            st_next.rdata[amc_pkg::ST_BUS]              = st_reg.bus_mode;
            st_next.rdata[amc_pkg::ST_MASTER]           = st_reg.master;
            st_next.rdata[amc_pkg::ST_GAIN +: amc_pkg::GAIN_W] = st_reg.gain;
            st_next.rdata[amc_pkg::ST_CHARGED]          = st_reg.charged;
         end
      end
      else if (!psel)
      begin
         st_next.rdata = '0;
         st_next.err   = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg       <= '0;
         st_reg.state <= amc_pkg::AMC_OFF;
      end
      else
         st_reg <= st_next;
   end

   // zero wait state slave
   assign pready  = 1'b1;
   assign prdata  = st_reg.rdata;
   assign pslverr = psel && penable && st_reg.err;

   // master drives the pin, slave leaves it to the chain
   assign shared_clock_pin_o    = st_reg.master && st_reg.shclk;
   assign shared_clock_pin_oe_n = !(st_reg.master &&
                                    st_reg.state != amc_pkg::AMC_OFF);

   assign bridge_switch = st_reg.brg;
   assign bridge_active = st_reg.active;
   assign audio_gain    = st_reg.gain;
   assign amp_state     = st_reg.state;

endmodule

//--- amc_mode_clock_checker.sv
// assertions on the mode and clock-role ports
// bound into amc_mode_clock; one pclk domain, control strap tracked while off
`timescale 1ns/100ps
module amc_mode_clock_checker
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        power_on_pin,
   input wire logic        quiet_release_pin,
   input wire logic        bus_address_strap,
   input wire logic        shared_clock_pin_o,
   input wire logic        shared_clock_pin_oe_n,
   input wire logic        bridge_active,
   input wire logic [7:0]  audio_gain,
   input wire logic [3:0]  amp_state
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic                          pin_mode_q;
   logic [amc_pkg::CHG_W-1:0]     qr_cnt;
   // control mode as latched on leaving off; run length of quiet release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_mode_q <= 1'b0;
         qr_cnt     <= '0;
      end
      else
      begin
         if (amp_state == 4'h1)
            pin_mode_q <= !bus_address_strap;
         if (!quiet_release_pin)
            qr_cnt <= '0;
         else if (qr_cnt != '1)
            qr_cnt <= qr_cnt + amc_pkg::CHG_W'(1);
      end
   end
   property p_off; amp_state == 4'h1 |-> !bridge_active && shared_clock_pin_oe_n; endproperty
   a_off: assert property (p_off) else $error("off state not idle");
   property p_low; !power_on_pin [*5] |-> amp_state == 4'h1; endproperty
   a_low: assert property (p_low) else $error("not off with power low");
   property p_high; power_on_pin [*5] |-> amp_state != 4'h1; endproperty
   a_high: assert property (p_high) else $error("not enabled");
   property p_cmd; psel && penable && pwrite && paddr == 8'h00 && power_on_pin
      && !pin_mode_q && amp_state != 4'h1 |-> ##2 amp_state ==
      (!$past(pwdata[0], 2) ? 4'h2 : $past(pwdata[8], 2) ? 4'h4 : 4'h8); endproperty
   a_cmd: assert property (p_cmd) else $error("bad command decode");
   property p_ramp; audio_gain != $past(audio_gain) && amp_state != 4'h1
      |-> 8'(audio_gain - $past(audio_gain)) inside {8'h01, 8'hFF}; endproperty
   a_ramp: assert property (p_ramp) else $error("gain stepped");
   property p_step; audio_gain != $past(audio_gain)
      |=> ($stable(audio_gain) || amp_state == 4'h1) [*8]; endproperty
   a_step: assert property (p_step) else $error("gain ramp too fast");
   property p_mute; amp_state == 4'h4 && $past(amp_state) == 4'h4
      |-> bridge_active && audio_gain <= $past(audio_gain); endproperty
   a_mute: assert property (p_mute) else $error("mute not idle");
   property p_osc; !shared_clock_pin_oe_n && $changed(shared_clock_pin_o)
      |=> ($stable(shared_clock_pin_o) || shared_clock_pin_oe_n) [*8]
      ##1 ($changed(shared_clock_pin_o) || shared_clock_pin_oe_n); endproperty
   a_osc: assert property (p_osc) else $error("master clock period");
   property p_pin; $rose(amp_state == 4'h8) && pin_mode_q
      |-> qr_cnt >= amc_pkg::CHG_W'(amc_pkg::CHARGE_CYC); endproperty
   a_pin: assert property (p_pin) else $error("operate before charge");
   c_oper: cover property (amp_state == 4'h8);
   c_mute: cover property (amp_state == 4'h4);
   c_stby: cover property (amp_state == 4'h2);
endmodule

bind amc_mode_clock amc_mode_clock_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable,
   .pwrite, .pwdata, .power_on_pin, .quiet_release_pin, .bus_address_strap,
   .shared_clock_pin_o, .shared_clock_pin_oe_n, .bridge_active, .audio_gain, .amp_state);

//--- amc_apb_host.sv
// apb master standing in for the host controller that issues mode commands
// assumes the slave may stretch the access phase; one transfer at a time
`timescale 1ns/100ps
module amc_apb_host
(
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic [7:0]       paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      pwdata
);
   initial
   begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e, output logic ok);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      ok = 1'b0;
      for (int n = 0; n < 16 && !ok; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
         begin
            ok = 1'b1;
            q = prdata;
            e = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show no stale value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

//--- test_amp_mode_and_clock_select.sv
// self-checking bench for the mode and clock-role logic
// host model drives apb; bench drives pins and the slave link clock
`timescale 1ns/100ps
module test_amp_mode_and_clock_select;
   logic        pclk, presetn, lclk, lclk_en, psel, penable, pwrite, pready, pslverr, e, ok;
   logic        power_on_pin, quiet_release_pin, bus_address_strap, timing_resistor_pin;
   logic        shared_clock_pin_o, shared_clock_pin_oe_n, bridge_switch, bridge_active;
   logic [7:0]  paddr, audio_gain;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  amp_state;
   int          bad_count, comparisons;
   // shared pin: device drives when enabled, else the external clock
   wire shared_clock_pin_i = shared_clock_pin_oe_n ? lclk : shared_clock_pin_o;
   amc_mode_clock u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
      .prdata, .pslverr, .power_on_pin, .quiet_release_pin, .bus_address_strap,
      .timing_resistor_pin, .shared_clock_pin_i, .shared_clock_pin_o, .shared_clock_pin_oe_n,
      .bridge_switch, .bridge_active, .audio_gain, .amp_state);
   amc_apb_host u_host (.pclk, .pready, .prdata, .pslverr, .paddr, .psel, .penable, .pwrite,
      .pwdata);
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      lclk = 1'b0;
      #7;
      forever #15 lclk = lclk_en ? ~lclk : 1'b0;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_state(input logic [3:0] s, input int n);
      for (int i = 0; i < n && amp_state !== s; i++) @(posedge pclk);
      if (amp_state !== s)
      begin
         check("state_wait", amp_state, s);
         finish_test();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(w, a, d, q, e, ok);
      if (ok !== 1'b1)
      begin
         check("pready_wait", ok, 1);
         finish_test();
      end
   endtask
   task automatic t_bus;
      logic [1:0] codes [4] = '{2'b01, 2'b11, 2'b00, 2'b10};
      bus(1'b1, 8'h00, 32'h1);
      check("cmd_off_err", e, 0);
      @(posedge pclk) power_on_pin <= 1'b1;
      wait_state(4'h2, 8);
      repeat (4) @(posedge pclk);
      check("bus_standby", amp_state, 4'h2);
      bus(1'b0, 8'h04, 32'h0);
      check("bus_master", q[5:4], 2'b11);
      check("master_oe_n", shared_clock_pin_oe_n, 0);
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, 8'h00, {16'h0, 7'h0, codes[k][1], 7'h0, codes[k][0]});
         repeat (3) @(posedge pclk);
         check("bus_state", amp_state, !codes[k][0] ? 4'h2 : codes[k][1] ? 4'h4 : 4'h8);
      end
      bus(1'b0, 8'h08, 32'h0);
      check("unmapped_err", e, 1);
      // strap moved while on must not change control mode
      @(posedge pclk) bus_address_strap <= 1'b0;
      bus(1'b1, 8'h00, 32'h1);
      repeat (3) @(posedge pclk);
      check("strap_latched", amp_state, 4'h8);
      @(posedge pclk) power_on_pin <= 1'b0;
      wait_state(4'h1, 8);
      check("off_bridge", bridge_active, 0);
   endtask
   task automatic t_pin;
      int n;
      logic last;
      logic [7:0] g;
      n = 0;
      last = 1'b0;
      @(posedge pclk) timing_resistor_pin <= 1'b0;
      lclk_en <= 1'b1;
      @(posedge pclk) power_on_pin <= 1'b1;
      wait_state(4'h4, 8);
      check("pin_default", amp_state, 4'h4);
      check("mute_bridge", bridge_active, 1);
      check("slave_oe_n", shared_clock_pin_oe_n, 1);
      repeat (200)
      begin
         @(posedge pclk);
         n += (bridge_switch !== last);
         last = bridge_switch;
      end
      check("slave_switch", n >= 120 && n <= 146, 1);
      @(posedge pclk) quiet_release_pin <= 1'b1;
      repeat (2000) @(posedge pclk);
      check("charging", amp_state, 4'h4);
      wait_state(4'h8, 700);
      repeat (1000) @(posedge pclk);
      g = audio_gain;
      check("gain_up", g >= 8'h08 && g <= 8'h0B, 1);
      @(posedge pclk) quiet_release_pin <= 1'b0;
      wait_state(4'h4, 8);
      repeat (300) @(posedge pclk);
      check("gain_down", audio_gain < g, 1);
      @(posedge pclk) power_on_pin <= 1'b0;
      wait_state(4'h1, 8);
      lclk_en <= 1'b0;
   endtask
   initial
   begin
      presetn = 1'b0;
      lclk_en = 1'b0;
      power_on_pin = 1'b0;
      quiet_release_pin = 1'b0;
      bus_address_strap = 1'b1;
      timing_resistor_pin = 1'b1;
      bad_count = 0;
      comparisons = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      check("reset_state", amp_state, 4'h1);
      t_bus();
      t_pin();
      finish_test();
   end
endmodule
